// *** logic/stc_pkg.sv ***
// Package: frame layout, command map and mode codes of the SPI target port
package stc_pkg;
  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam int ADDR_W = 7;
  localparam int RW_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int DATA_W = 16;
  localparam int CMD_W = 24;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h3F;
  // Reply word fields, shifted out least significant bit first
  localparam int REPLY_ERR_BIT = 0;
  localparam int REPLY_FAIL_BIT = 1;
  localparam int REPLY_MODE_LSB = 2;
  // Command map
  localparam logic [6:0] MODE_ADDR = 7'h01;
  localparam logic [6:0] WDOG_ADDR = 7'h02;
  localparam logic [6:0] STAT_ADDR = 7'h3F;
  localparam int CLEAR_FAIL_BIT = 0;
  localparam int FIFO_DEPTH = 16;
  // Device operating modes
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_INIT = 3'h0;
  localparam logic [2:0] MODE_NORMAL = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;
  localparam logic [2:0] MODE_FAILSAFE = 3'h5;
  // Reset levels of the select synchroniser (deselected)
  localparam logic CS_RST = 1'b1;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_PEND} stc_state_t;
endpackage : stc_pkg

// *** logic/stc_spi_target.sv ***
// SPI target command port with its command FIFO
`timescale 1ns/1ps

module stc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("stc_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } stc_fifo_st_t;

  stc_fifo_st_t r, n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign empty = (r.wp == r.rp);
  assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[r.rp[AW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_comb begin
    n = r;
    if (push) begin
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
    if (push) begin
      mem[r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : stc_fifo

// Overview of operation
// R01: Port works in init, normal and stop modes.
// R02: Port is off and ignores traffic in sleep, restart, fail-safe.
// R03: Full-duplex 32-bit frames; each target has its own select.
// R04: Frame starts when select goes low; shifting only while low.
// R05: Received word is decoded only after select rises.
// R06: Serial output released to high impedance when select rises.
// R07: Input bit sampled on every falling link clock edge.
// R08: Next output bit driven after each rising link clock edge.
// R09: Input is never passed through to the output.
// R10: Illegal writes are dropped whole and set the rejection flag.
// R11: Rejection flag holds until an explicit clear command.
// R12: Address bits 6:0, selector bit 7, data bits 23:8.
// R13: Bad clock count or clock high at select edge flags next frame.
// R14: Select high: clock and input ignored, state unchanged.
module stc_spi_target
  import stc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins
  input wire logic target_select_low,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Device side
  input wire logic [2:0] dev_mode,
  input wire logic [DATA_W-1:0] resp_data,
  // Accepted commands
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [CMD_W-1:0] cmd_data,
  // Status
  output logic spi_fail,
  output logic frame_err
);
  typedef struct packed {
    stc_state_t st;
    logic cs_m;
    logic cs_s;
    logic cs_q;
    logic ck_m;
    logic ck_s;
    logic ck_q;
    logic di_m;
    logic di_s;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic [5:0] cnt;
    logic ck_bad;
    logic err;
    logic fail;
    logic sdo;
    logic [CMD_W-1:0] pend;
  } stc_st_t;

  stc_st_t r, n;
  logic port_en;
  logic fall;
  logic rise;
  logic sel_fall;
  logic bad_end;
  logic rej;
  logic clr;
  logic [1:0] chk;
  logic fifo_in_ready;

  // Returns {reject, clear} for a complete command word
  function automatic logic [1:0] stc_check(input logic [CMD_W-1:0] w,
                                           input logic [2:0] m);
    logic wr;
    logic [ADDR_W-1:0] a;
    logic [2:0] req;
    logic rj;
    logic cl;
    wr = w[RW_BIT]; // [R12]
    a = w[ADDR_W-1:0]; // [R12]
    req = w[DATA_LSB +: MODE_W]; // [R12]
    rj = 1'b0;
    cl = 1'b0;
    if (wr && a == STAT_ADDR) begin
      cl = w[DATA_LSB + CLEAR_FAIL_BIT]; // [R11]
    end else if (wr && a == MODE_ADDR) begin
      rj = (req != MODE_NORMAL && req != MODE_STOP && req != MODE_SLEEP)
        || (m == MODE_STOP && req == MODE_SLEEP)
        || (m == MODE_INIT && req != MODE_NORMAL); // [R10]
    end else if (wr && a != WDOG_ADDR) begin
      // Stop mode only allows mode change, watchdog and status clear
      rj = (m == MODE_STOP); // [R10]
    end
    return {rj, cl};
  endfunction : stc_check

  assign port_en = (dev_mode == MODE_INIT) || (dev_mode == MODE_NORMAL)
    || (dev_mode == MODE_STOP); // [R01] [R02]
  assign fall = r.ck_q && !r.ck_s;
  assign rise = !r.ck_q && r.ck_s;
  assign sel_fall = r.cs_q && !r.cs_s;
  assign bad_end = r.ck_s || r.ck_bad
    || (r.cnt != 6'h00 && r.cnt != CNT_FULL); // [R13]
  assign chk = stc_check(r.rx[CMD_W-1:0], dev_mode);

  always_comb begin
    n = r;
    rej = 1'b0;
    clr = 1'b0;
    // Pins cross into clk through two flops each
    n.cs_m = target_select_low;
    n.cs_s = r.cs_m;
    n.cs_q = r.cs_s;
    n.ck_m = sclk;
    n.ck_s = r.ck_m;
    n.ck_q = r.ck_s;
    n.di_m = sdi;
    n.di_s = r.di_m;
    case (r.st)
      ST_IDLE: begin
        // Select high: nothing shifts [R14]
        if (port_en && sel_fall) begin
          n.st = ST_FRAME; // [R04]
          n.ck_bad = r.ck_s; // [R13]
          n.tx = {8'h00, resp_data, 3'h0, dev_mode, r.fail, r.err};
          n.sdo = r.err; // [R13]
          n.err = 1'b0;
        end
      end
      ST_FRAME: begin
        if (!port_en) begin
          n.st = ST_IDLE; // [R02]
          n.cnt = 6'h00;
        end else if (r.cs_s) begin
          n.st = ST_IDLE; // [R05] [R06]
          n.cnt = 6'h00;
          if (bad_end) begin
            n.err = 1'b1; // [R13]
          end else if (r.cnt == CNT_FULL) begin
            clr = chk[0]; // [R11]
            rej = chk[1]; // [R10]
            if (!chk[1]) begin
              n.pend = r.rx[CMD_W-1:0]; // [R05]
              n.st = ST_PEND;
            end
          end
        end else begin
          if (fall) begin
            n.rx = {r.di_s, r.rx[FRAME_BITS-1:1]}; // [R07] [R03]
            if (r.cnt != CNT_SAT) begin
              n.cnt = r.cnt + 6'h01;
            end
          end
          if (rise) begin
            // Output comes only from the reply word [R09]
            n.tx = {1'b0, r.tx[FRAME_BITS-1:1]}; // [R08]
            n.sdo = r.tx[1]; // [R08]
          end
        end
      end
      ST_PEND: begin
        // Full FIFO stalls here; frames are not accepted meanwhile
        if (fifo_in_ready) begin
          n.st = ST_IDLE;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // Set wins over clear
    if (clr) begin
      n.fail = 1'b0; // [R11]
    end
    if (rej) begin
      n.fail = 1'b1; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.cs_m <= CS_RST;
      r.cs_s <= CS_RST;
      r.cs_q <= CS_RST;
    end else begin
      r <= n;
    end
  end

  stc_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(r.st == ST_PEND),
    .in_ready(fifo_in_ready),
    .in_data(r.pend),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_data)
  );

  assign sdo = r.sdo;
  assign sdo_oe = (r.st == ST_FRAME); // [R06]
  assign spi_fail = r.fail;
  assign frame_err = r.err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_frame_end;
    (r.st == ST_FRAME) && port_en && r.cs_s;
  endsequence

  sequence s_good_end;
    s_frame_end ##0 !bad_end && (r.cnt == CNT_FULL);
  endsequence

  property p_off_quiet;
    !port_en |=> !sdo_oe;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // [R02]
    else $error("port drives output while switched off");

  property p_start;
    (r.st == ST_IDLE) && port_en && sel_fall |=> sdo_oe;
  endproperty
  a_start: assert property (p_start) // [R01]
    else $error("frame did not start on select fall");

  property p_release;
    s_frame_end |=> !sdo_oe;
  endproperty
  a_release: assert property (p_release) // [R06]
    else $error("output not released after select rise");

  property p_sample;
    (r.st == ST_FRAME) && !r.cs_s && port_en && fall
      |=> r.rx[FRAME_BITS-1] == $past(r.di_s);
  endproperty
  a_sample: assert property (p_sample) // [R07]
    else $error("input bit not sampled on falling edge");

  property p_shift;
    (r.st == ST_FRAME) && !r.cs_s && port_en && rise
      |=> sdo == $past(r.tx[1]);
  endproperty
  a_shift: assert property (p_shift) // [R08]
    else $error("output bit not advanced on rising edge");

  property p_hold_out;
    (r.st == ST_FRAME) && !r.cs_s && !rise |=> $stable(sdo);
  endproperty
  a_hold_out: assert property (p_hold_out) // [R09]
    else $error("output changed without a rising edge");

  property p_reject;
    s_good_end ##0 chk[1] |=> spi_fail && (r.st == ST_IDLE);
  endproperty
  a_reject: assert property (p_reject) // [R10]
    else $error("illegal command not rejected");

  property p_sticky;
    spi_fail && !((r.st == ST_FRAME) && port_en && r.cs_s && !bad_end
      && (r.cnt == CNT_FULL) && chk[0]) |=> spi_fail;
  endproperty
  a_sticky: assert property (p_sticky) // [R11]
    else $error("rejection flag dropped without clear");

  property p_bad_frame;
    s_frame_end ##0 bad_end |=> frame_err && (r.st == ST_IDLE);
  endproperty
  a_bad_frame: assert property (p_bad_frame) // [R13]
    else $error("bad frame not flagged");

  property p_err_shown;
    (r.st == ST_IDLE) && port_en && sel_fall && frame_err |=> sdo;
  endproperty
  a_err_shown: assert property (p_err_shown) // [R13]
    else $error("error flag not on first output bit");

  property p_decode_late;
    $rose(r.st == ST_PEND) |-> $past(r.cs_s) && $past(r.st) == ST_FRAME;
  endproperty
  a_decode_late: assert property (p_decode_late) // [R05]
    else $error("command decoded before select rise");

  property p_idle_still;
    (r.st != ST_FRAME) |=> $stable(r.rx) && $stable(r.cnt);
  endproperty
  a_idle_still: assert property (p_idle_still) // [R14]
    else $error("receive state moved outside a frame");
endmodule : stc_spi_target

// *** testbench/stc_spi_host.sv ***
// Controller model of the serial link
`timescale 1ns/1ps
module stc_spi_host (
  // Clock
  clk,
  // Link pins
  target_select_low,
  sclk,
  sdi,
  sdo,
  sdo_oe
);
  input wire logic clk;
  output logic target_select_low;
  output logic sclk;
  output logic sdi;
  input wire logic sdo;
  input wire logic sdo_oe;
  logic seen_oe;
  initial begin
    target_select_low = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    seen_oe = 1'b0;
  end
  // Idle data toggles so a stale bit never passes for a good one
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      sdi <= ~sdi;
    end
  endtask : idle
  // Frame of n clocks, LSB first; clock idles low outside frames
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = '0;
    seen_oe = 1'b0;
    @(posedge clk);
    target_select_low <= 1'b0;
    sdi <= tx[0];
    repeat (8) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      // Released line reads inverted so a missing enable shows up
      rx[k] = sdo_oe ? sdo : !sdo;
      seen_oe |= sdo_oe;
      @(posedge clk);
      sclk <= 1'b1;
      sdi <= tx[k];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    @(negedge clk);
    if (n == 0) rx[0] = sdo_oe ? sdo : !sdo;
    seen_oe |= sdo_oe;
    @(posedge clk);
    target_select_low <= 1'b1;
    idle(10);
  endtask : xfer
endmodule : stc_spi_host

// *** testbench/stc_spi_target_tb.sv ***
// Self-checking bench of the SPI target command port
`timescale 1ns/1ps
module stc_spi_target_tb;
  import stc_pkg::*;
  localparam int FIFO_D = 2;
  logic clk, sys_rst, target_select_low, sclk, sdi, sdo, sdo_oe;
  logic cmd_valid, spi_fail, frame_err, hold_rdy, fail_m, err_m;
  logic cmd_ready = 1'b0;
  logic [2:0] dev_mode;
  logic [DATA_W-1:0] resp_data;
  logic [CMD_W-1:0] cmd_data;
  logic [31:0] seed, rx;
  logic [CMD_W-1:0] expq[$];
  int error_cnt, checked;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  stc_spi_target #(.DEPTH(FIFO_D)) dut (.clk(clk), .sys_rst(sys_rst),
    .target_select_low(target_select_low), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .dev_mode(dev_mode),
    .resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_data(cmd_data), .spi_fail(spi_fail), .frame_err(frame_err));
  stc_spi_host host (.clk(clk), .target_select_low(target_select_low),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("Errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Consumer stalls every other cycle while hold_rdy is low
  always @(posedge clk) begin
    cmd_ready <= ~hold_rdy & ~cmd_ready;
    if (cmd_valid && cmd_ready) begin
      check(cmd_data, expq.size() ? expq.pop_front() : 24'hFFFFFF);
    end
  end
  task automatic setup(input logic [2:0] m, input logic [15:0] r);
    @(posedge clk);
    dev_mode <= m;
    resp_data <= r;
    @(posedge clk);
  endtask : setup
  task automatic frame(input logic [31:0] tx, input int n);
    logic [31:0] exp;
    logic on, rej;
    // A full buffer with one word waiting stalls the port
    on = (dev_mode <= MODE_STOP) && (expq.size() <= FIFO_D);
    exp = {8'h00, resp_data, 3'h0, dev_mode, fail_m, err_m};
    rej = tx[7] && ((tx[6:0] == MODE_ADDR
      && (!(tx[10:8] inside {3'h1, 3'h2, 3'h3})
      || (dev_mode == MODE_STOP && tx[10:8] == MODE_SLEEP)
      || (dev_mode == MODE_INIT && tx[10:8] != MODE_NORMAL)))
      || (dev_mode == MODE_STOP
      && !(tx[6:0] inside {MODE_ADDR, WDOG_ADDR, STAT_ADDR})));
    if (on && n == 32 && !rej) expq.push_back(tx[23:0]);
    host.xfer(tx, n, rx);
    if (!on) check(host.seen_oe, 1'b0);
    else if (n == 0) check(rx[0], err_m);
    else if (n == 32) check(rx, exp);
    if (on) err_m = n != 0 && n != 32;
    if (on && n == 32 && rej) fail_m = 1'b1;
    else if (on && n == 32 && tx[7] && tx[6:0] == STAT_ADDR && tx[8])
      fail_m = 1'b0;
    check(spi_fail, fail_m);
    check(frame_err, err_m);
  endtask : frame
  initial begin
    sys_rst = 1'b1;
    dev_mode = MODE_NORMAL;
    resp_data = '0;
    hold_rdy = 1'b0;
    seed = 32'hB562D085;
    fail_m = 1'b0;
    err_m = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check({sdo_oe, cmd_valid, spi_fail, frame_err}, 4'h0);
    host.idle(4);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      setup(3'(i % 6), seed[31:16]);
      frame({8'h00, seed[23:0]}, 32);
    end
    // Every mode request from every enabled mode, then a clear
    for (int c = 0; c < 24; c++) begin
      setup(3'(c / 8), 16'hA5C3);
      frame({8'h00, 13'h0, 3'(c % 8), 1'b1, MODE_ADDR}, 32);
      frame({8'h00, 16'h0001, 1'b1, STAT_ADDR}, 32);
    end
    // Bad counts, each followed by probes without clocks
    setup(MODE_NORMAL, 16'h1234);
    frame(32'h0, 5);
    frame(32'h0, 0);
    frame(32'h0, 31);
    frame(32'h0, 0);
    frame(32'h0, 0);
    // Full buffer stalls the port
    hold_rdy <= 1'b1;
    repeat (4) frame(32'h00_5A_00_11, 32);
    hold_rdy <= 1'b0;
    repeat (30) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    hold_rdy <= 1'b1;
    repeat (3) frame(32'h00_00_00_22, 32);
    host.xfer(32'h0, 32, rx);
    check(host.seen_oe, 1'b0);
    hold_rdy <= 1'b0;
    repeat (30) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule : stc_spi_target_tb
